// ==== verilog/swfd_defs.vh ====
// constants of the single-wire frame decoder
`ifndef SWFD_DEFS_VH
`define SWFD_DEFS_VH

`define SWFD_CLK_PS 25000
`define SWFD_BIT_TIME_PS 172800000

`define SWFD_OFF_CTRL 4'h0
`define SWFD_OFF_STATUS 4'h4
`define SWFD_OFF_INSTR 4'h8

`define SWFD_CTRL_CHIP 0
`define SWFD_CTRL_LOCK 1
`define SWFD_CTRL_SPD_LO 2
`define SWFD_CTRL_SPD_HI 3
`define SWFD_CTRL_RESET 4'h4

`define SWFD_ST_ERR 0
`define SWFD_ST_SLEEP 1
`define SWFD_ST_IGNORE 2
`define SWFD_ST_STATE_LO 4
`define SWFD_ST_STATE_HI 7

`define SWFD_OP_WRITE 2'h0
`define SWFD_OP_READ 2'h1
`define SWFD_OP_READ_CRC 2'h2
`define SWFD_OP_SLEEP 2'h3

`define SWFD_BANK_OTP 2'h0
`define SWFD_BANK_CTRL 2'h1
`define SWFD_BANK_AUTH 2'h2
`define SWFD_BANK_TEST 2'h3

`define SWFD_ADDR_STATUS 8'h01
`define SWFD_ADDR_CHALLENGE 8'h01

`define SWFD_CRC_POLY 8'h8c

`endif

// ==== verilog/swfd_crc8.v ====
// serial crc-8, polynomial 1 + x^4 + x^5 + x^8, lsb-first input
`timescale 1ns/1ps
`include "swfd_defs.vh"
module swfd_crc8 (
  input wire clk,
  input wire reset,
  input wire clr,
  input wire en,
  input wire din,
  output reg [7:0] crc_q
);
  wire fb;
  assign fb = crc_q[0] ^ din;
  always @(posedge clk) begin
    if (reset || clr) begin
      crc_q <= 8'h00; // see (R17)
    end else if (en) begin
      crc_q <= {1'b0, crc_q[7:1]} ^ (fb ? `SWFD_CRC_POLY : 8'h00); // see (R16)
    end
  end
endmodule // swfd_crc8

// ==== verilog/swfd_frame_decoder.v ====
// frame-level sequencer of the single-wire slave link
//
// Notes on behaviour
// (R01) op 00 writes following data frames; op 01 does a plain read.
// (R02) op 10 reads, then sends one crc byte after the last data byte.
// (R03) op 11 puts the device to sleep right after the opcode bits.
// (R04) host stops pulsing after three bits of a sleep frame.
// (R05) bank field 00 otp, 01 control/status, 10 authentication, 11 test.
// (R06) address field is the first location; multi-byte steps upward.
// (R07) host uses odd start addresses for the otp bank.
// (R08) byte count field gives data bytes, crc excluded; 1, 2, 4 literal.
// (R09) count code 7 means 16 bytes, only otp read before lock-out.
// (R10) count codes 0, 3, 5, 6 raise a bus error.
// (R11) host writes otp two bytes, reads it 2, 4 or 16 bytes.
// (R12) status clears on a single-byte read of it.
// (R13) host makes sure the device is awake, e.g. by a break.
// (R14) host gaps up to 800 ms; device gap and turnaround one bit time.
// (R15) crc generated only for op 10 reads, over the sent data.
// (R16) crc lfsr uses polynomial 1 + x^4 + x^5 + x^8.
// (R17) crc register cleared to zero before each computation.
// (R18) each read bit enters the crc as it goes on the wire.
// (R19) crc sent after the last data byte, lsb first.
// (R20) write, read, and read followed by write without sleep.
// (R21) 16-bit instruction frame first; all fields lsb first.
// (R22) chip-select mismatch ignores everything until a break.
// (R23) symbols: one is 0.3 bit time low, zero 0.7 bit time.
// (R24) frame order: chip select, opcode, bank, address, byte count.
// (R25) challenge write only 4 bytes; other registers only 1 or 2 bytes.
`timescale 1ns/1ps
`include "swfd_defs.vh"
module swfd_frame_decoder #(
  parameter BT_CYCLES = `SWFD_BIT_TIME_PS / `SWFD_CLK_PS
) (
  input wire CLK,
  input wire RESET,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  input wire SYM_VALID,
  input wire SYM_BIT,
  input wire SYM_BREAK,
  input wire SYM_GLITCH,
  output reg TX_REQ,
  output reg TX_BIT,
  input wire TX_DONE,
  output reg REG_RD,
  output reg REG_WR,
  output reg [1:0] REG_BANK,
  output reg [7:0] REG_ADDR,
  output reg [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire REG_RVALID,
  output reg STAT_CLR,
  output reg SLEEP,
  output reg BUS_ERR
);
  localparam S_INSTR = 4'h0;
  localparam S_IGNORE = 4'h1;
  localparam S_WDATA = 4'h2;
  localparam S_RFETCH = 4'h3;
  localparam S_RWAIT = 4'h4;
  localparam S_RGAP = 4'h5;
  localparam S_RSHIFT = 4'h6;
  localparam S_RTXW = 4'h7;
  localparam S_SLEEP = 4'h8;

  localparam [15:0] BT_X1 = BT_CYCLES[15:0];

  // byte count code to number of data bytes, zero when invalid
  function [4:0] bytes_of;
    input [2:0] code;
    begin
      case (code)
        3'h1: bytes_of = 5'h01; // see (R08)
        3'h2: bytes_of = 5'h02;
        3'h4: bytes_of = 5'h04;
        3'h7: bytes_of = 5'h10; // see (R09)
        default: bytes_of = 5'h00; // see (R10)
      endcase
    end
  endfunction

  // whole-frame legality check
  function frame_ok;
    input [15:0] f;
    input lock;
    reg [1:0] op;
    reg [1:0] bank;
    reg [7:0] addr;
    reg [2:0] cnt;
    reg [4:0] n;
    begin
      op = f[2:1];
      bank = f[4:3];
      addr = f[12:5];
      cnt = f[15:13];
      n = bytes_of(cnt);
      frame_ok = 1'b1;
      if (n == 5'h00) begin
        frame_ok = 1'b0; // see (R10)
      end else if (cnt == 3'h7) begin
        frame_ok = (op != `SWFD_OP_WRITE) && (bank == `SWFD_BANK_OTP) &&
                   !lock; // see (R09)
      end else if (bank == `SWFD_BANK_AUTH &&
                   addr == `SWFD_ADDR_CHALLENGE &&
                   op == `SWFD_OP_WRITE) begin
        frame_ok = (n == 5'h04); // see (R25)
      end else if (bank != `SWFD_BANK_OTP) begin
        frame_ok = (n == 5'h01) || (n == 5'h02); // see (R25)
      end
    end
  endfunction

  reg [3:0] state_q;
  reg [15:0] instr_q;
  reg [3:0] bitcnt_q;
  reg [2:0] txcnt_q;
  reg [4:0] remain_q;
  reg [7:0] shreg_q;
  reg [15:0] timer_q;
  reg crc_mode_q;
  reg crc_phase_q;
  reg crc_clr_q;
  reg chip_q;
  reg lock_q;
  reg [1:0] speed_q;
  reg err_q;
  reg [15:0] bt_cycles;
  wire [7:0] crc_val;
  wire crc_en;
  wire [15:0] frame;
  wire av_go;
  wire err_set;
  wire [31:0] rd_mux;
  wire [3:0] ctrl_rst;

  assign ctrl_rst = `SWFD_CTRL_RESET;

  // one bit time in cycles; speed codes 0..3 give x = 2, 1, 0.5, 0.25
  always @* begin
    case (speed_q)
      2'h0: bt_cycles = {BT_X1[14:0], 1'b0};
      2'h1: bt_cycles = BT_X1;
      2'h2: bt_cycles = {1'b0, BT_X1[15:1]};
      default: bt_cycles = {2'b00, BT_X1[15:2]};
    endcase
  end

  assign frame = {SYM_BIT, instr_q[14:0]};
  assign crc_en = TX_REQ && crc_mode_q && !crc_phase_q; // see (R15) (R18)
  assign av_go = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign err_set = BUS_ERR;

  swfd_crc8 u_crc (
    .clk(CLK),
    .reset(RESET),
    .clr(crc_clr_q),
    .en(crc_en),
    .din(TX_BIT),
    .crc_q(crc_val)
  );

  // frame sequencer
  always @(posedge CLK) begin
    if (RESET) begin
      state_q <= S_INSTR;
      instr_q <= 16'h0000;
      bitcnt_q <= 4'h0;
      txcnt_q <= 3'h0;
      remain_q <= 5'h00;
      shreg_q <= 8'h00;
      timer_q <= 16'h0000;
      crc_mode_q <= 1'b0;
      crc_phase_q <= 1'b0;
      crc_clr_q <= 1'b0;
      TX_REQ <= 1'b0;
      TX_BIT <= 1'b1;
      REG_RD <= 1'b0;
      REG_WR <= 1'b0;
      REG_BANK <= 2'h0;
      REG_ADDR <= 8'h00;
      REG_WDATA <= 8'h00;
      STAT_CLR <= 1'b0;
      SLEEP <= 1'b0;
      BUS_ERR <= 1'b0;
    end else begin
      TX_REQ <= 1'b0;
      REG_RD <= 1'b0;
      REG_WR <= 1'b0;
      STAT_CLR <= 1'b0;
      BUS_ERR <= 1'b0;
      crc_clr_q <= 1'b0;
      if (REG_WR) begin
        REG_ADDR <= REG_ADDR + 8'h01; // see (R06)
      end
      if (SYM_BREAK) begin
        // a break restarts framing, wakes and leaves the ignore state
        state_q <= S_INSTR; // see (R22)
        bitcnt_q <= 4'h0;
        SLEEP <= 1'b0;
      end else if (SYM_GLITCH && state_q != S_SLEEP) begin
        BUS_ERR <= 1'b1;
        state_q <= S_IGNORE;
      end else begin
        case (state_q)
          S_INSTR: begin
            if (SYM_VALID) begin
              instr_q[bitcnt_q] <= SYM_BIT; // see (R21) (R23) (R24)
              bitcnt_q <= bitcnt_q + 4'h1;
              if (bitcnt_q == 4'h0 && SYM_BIT != chip_q) begin
                state_q <= S_IGNORE; // see (R22)
              end else if (bitcnt_q == 4'h2 &&
                           {SYM_BIT, instr_q[1]} == `SWFD_OP_SLEEP) begin
                state_q <= S_SLEEP; // see (R03)
                SLEEP <= 1'b1;
              end else if (bitcnt_q == 4'hf) begin
                bitcnt_q <= 4'h0;
                REG_BANK <= frame[4:3]; // see (R05)
                REG_ADDR <= frame[12:5]; // see (R06)
                remain_q <= bytes_of(frame[15:13]); // see (R08)
                crc_mode_q <= (frame[2:1] == `SWFD_OP_READ_CRC); // see (R02)
                crc_phase_q <= 1'b0;
                crc_clr_q <= 1'b1; // see (R17)
                txcnt_q <= 3'h0;
                if (!frame_ok(frame, lock_q)) begin
                  BUS_ERR <= 1'b1; // see (R10)
                  state_q <= S_IGNORE;
                end else if (frame[2:1] == `SWFD_OP_WRITE) begin
                  state_q <= S_WDATA; // see (R01)
                end else begin
                  state_q <= S_RFETCH; // see (R01) (R02)
                end
              end
            end
          end
          S_WDATA: begin
            if (SYM_VALID) begin
              shreg_q <= {SYM_BIT, shreg_q[7:1]}; // see (R21)
              txcnt_q <= txcnt_q + 3'h1;
              if (txcnt_q == 3'h7) begin
                REG_WR <= 1'b1;
                REG_WDATA <= {SYM_BIT, shreg_q[7:1]};
                remain_q <= remain_q - 5'h01;
                if (remain_q == 5'h01) begin
                  state_q <= S_INSTR; // see (R20)
                end
              end
            end
          end
          S_RFETCH: begin
            REG_RD <= 1'b1;
            if (remain_q == 5'h01 && REG_BANK == `SWFD_BANK_CTRL &&
                REG_ADDR == `SWFD_ADDR_STATUS && !crc_phase_q &&
                instr_q[15:13] == 3'h1) begin
              STAT_CLR <= 1'b1; // see (R12)
            end
            state_q <= S_RWAIT;
          end
          S_RWAIT: begin
            if (REG_RVALID) begin
              shreg_q <= REG_RDATA;
              REG_ADDR <= REG_ADDR + 8'h01; // see (R06)
              timer_q <= bt_cycles; // see (R14)
              state_q <= S_RGAP;
            end
          end
          S_RGAP: begin
            if (timer_q <= 16'h0001) begin
              state_q <= S_RSHIFT;
            end else begin
              timer_q <= timer_q - 16'h0001;
            end
          end
          S_RSHIFT: begin
            TX_REQ <= 1'b1;
            TX_BIT <= shreg_q[0]; // see (R19) (R21)
            state_q <= S_RTXW;
          end
          S_RTXW: begin
            if (TX_DONE) begin
              shreg_q <= {1'b0, shreg_q[7:1]};
              txcnt_q <= txcnt_q + 3'h1;
              state_q <= S_RSHIFT;
              if (txcnt_q == 3'h7) begin
                if (crc_phase_q) begin
                  state_q <= S_INSTR; // see (R20)
                end else if (remain_q != 5'h01) begin
                  remain_q <= remain_q - 5'h01;
                  state_q <= S_RFETCH;
                end else if (crc_mode_q) begin
                  // crc_val already holds the last data bit
                  remain_q <= 5'h00;
                  crc_phase_q <= 1'b1;
                  shreg_q <= crc_val; // see (R19)
                  timer_q <= bt_cycles; // see (R14)
                  state_q <= S_RGAP;
                end else begin
                  remain_q <= 5'h00;
                  state_q <= S_INSTR;
                end
              end
            end
          end
          S_SLEEP: begin
            // any further pulse wakes the device again
            if (SYM_VALID) begin
              SLEEP <= 1'b0; // see (R04)
              state_q <= S_INSTR;
              bitcnt_q <= 4'h0;
            end
          end
          S_IGNORE: begin
            bitcnt_q <= 4'h0;
          end
          default: begin
            state_q <= S_INSTR;
          end
        endcase
      end
    end
  end

  assign rd_mux =
    (AVS_ADDRESS == `SWFD_OFF_CTRL) ?
      {28'h0000000, speed_q, lock_q, chip_q} :
    (AVS_ADDRESS == `SWFD_OFF_STATUS) ?
      {24'h000000, state_q, 1'b0, (state_q == S_IGNORE), SLEEP, err_q} :
    (AVS_ADDRESS == `SWFD_OFF_INSTR) ? {16'h0000, instr_q} : 32'h00000000;

  // avalon slave: one wait cycle, then the access completes
  always @(posedge CLK) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      chip_q <= ctrl_rst[`SWFD_CTRL_CHIP];
      lock_q <= ctrl_rst[`SWFD_CTRL_LOCK];
      speed_q <= ctrl_rst[`SWFD_CTRL_SPD_HI:`SWFD_CTRL_SPD_LO];
      err_q <= 1'b0;
    end else begin
      if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        AVS_READDATA <= AVS_READ ? rd_mux : 32'h00000000;
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
      if (av_go && AVS_WRITE && AVS_ADDRESS == `SWFD_OFF_CTRL) begin
        chip_q <= AVS_WRITEDATA[`SWFD_CTRL_CHIP];
        lock_q <= AVS_WRITEDATA[`SWFD_CTRL_LOCK];
        speed_q <= AVS_WRITEDATA[`SWFD_CTRL_SPD_HI:`SWFD_CTRL_SPD_LO];
      end
      // a new error wins over a write-one clear in the same cycle
      if (err_set) begin
        err_q <= 1'b1;
      end else if (av_go && AVS_WRITE && AVS_ADDRESS == `SWFD_OFF_STATUS &&
                   AVS_WRITEDATA[`SWFD_ST_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end
endmodule // swfd_frame_decoder

// ==== dv/swfd_properties.sv ====
// port assertions of the frame decoder
`timescale 1ns/1ps
module swfd_properties (
  input wire CLK,
  input wire RESET,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire AVS_WAITREQUEST,
  input wire SYM_VALID,
  input wire TX_REQ,
  input wire TX_BIT,
  input wire REG_RD,
  input wire REG_WR,
  input wire [1:0] REG_BANK,
  input wire [7:0] REG_ADDR,
  input wire STAT_CLR,
  input wire SLEEP,
  input wire BUS_ERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_wait_answer: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus access not answered one cycle later");
  chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  chk_stat_clear: assert property (
    STAT_CLR |-> REG_RD && REG_BANK == 2'h1 && REG_ADDR == 8'h01)
    else $error("status clear outside a status read");
  chk_tx_hold: assert property (TX_REQ || $stable(TX_BIT))
    else $error("transmit bit changed without a request");
  chk_err_pulse: assert property (BUS_ERR |=> !BUS_ERR)
    else $error("bus error longer than one cycle");
  chk_rw_apart: assert property (!(REG_RD && REG_WR))
    else $error("register read and write together");
  chk_addr_step: assert property (
    REG_WR |=> REG_ADDR == $past(REG_ADDR) + 8'h01)
    else $error("address did not step after a write");
  chk_sleep_entry: assert property ($rose(SLEEP) |-> $past(SYM_VALID))
    else $error("sleep entered without a symbol");
  chk_wr_single: assert property (REG_WR |=> !REG_WR [*2])
    else $error("register writes too close");
endmodule // swfd_properties

bind swfd_frame_decoder swfd_properties u_chk (.CLK, .RESET, .AVS_READ,
  .AVS_WRITE, .AVS_WAITREQUEST, .SYM_VALID, .TX_REQ, .TX_BIT, .REG_RD,
  .REG_WR, .REG_BANK, .REG_ADDR, .STAT_CLR, .SLEEP, .BUS_ERR);

// ==== dv/swfd_host_model.sv ====
// far-side model: register read/write responder and transmit bit collector
`timescale 1ns/1ps
module swfd_host_model (
  input wire CLK,
  input wire slow,
  input wire REG_RD,
  input wire REG_WR,
  input wire [1:0] REG_BANK,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire TX_REQ,
  input wire TX_BIT,
  output reg [7:0] REG_RDATA = 8'h00,
  output reg REG_RVALID = 1'b0,
  output reg TX_DONE = 1'b0
);
  bit bits[$];
  logic [17:0] wq[$];
  int rd_n = 0;
  always @(posedge CLK) if (REG_WR === 1'b1)
    wq.push_back({REG_BANK, REG_ADDR, REG_WDATA});
  always @(posedge CLK) begin
    if (REG_RD === 1'b1) begin
      rd_n++;
      repeat (slow ? 6 : 1) @(posedge CLK);
      REG_RDATA <= {REG_ADDR[5:0], REG_BANK} ^ 8'ha5;
      REG_RVALID <= 1'b1;
      @(posedge CLK);
      REG_RVALID <= 1'b0;
      // stale data is inverted so it never looks valid
      REG_RDATA <= ~REG_RDATA;
    end
  end
  always @(posedge CLK) begin
    if (TX_REQ === 1'b1) begin
      bits.push_back(TX_BIT);
      repeat (slow ? 8 : 3) @(posedge CLK);
      TX_DONE <= 1'b1;
      @(posedge CLK);
      TX_DONE <= 1'b0;
    end
  end
endmodule // swfd_host_model

// ==== dv/swfd_frame_decoder_test.sv ====
// self-checking bench of the frame decoder
`timescale 1ns/1ps
module swfd_frame_decoder_test;
  reg CLK = 0, RESET = 1, AVS_READ = 0, AVS_WRITE = 0, slow = 0;
  reg SYM_VALID = 0, SYM_BIT = 0, SYM_BREAK = 0, SYM_GLITCH = 0;
  reg [3:0] AVS_ADDRESS = 0;
  reg [31:0] AVS_WRITEDATA = 0, q;
  wire [31:0] AVS_READDATA;
  wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  wire [1:0] REG_BANK;
  wire AVS_WAITREQUEST, TX_REQ, TX_BIT, TX_DONE, REG_RD, REG_WR;
  wire REG_RVALID, STAT_CLR, SLEEP, BUS_ERR;
  int miscompares = 0, compares = 0, errs = 0, e0, stats = 0;
  int cl[6] = '{0, 3, 5, 6, 7, 2};
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) if (BUS_ERR === 1'b1) errs++;
  always @(posedge CLK) if (STAT_CLR === 1'b1) stats++;
  swfd_frame_decoder #(.BT_CYCLES(16)) u_dut (.CLK, .RESET, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
    .SYM_VALID, .SYM_BIT, .SYM_BREAK, .SYM_GLITCH, .TX_REQ, .TX_BIT,
    .TX_DONE, .REG_RD, .REG_WR, .REG_BANK, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .REG_RVALID, .STAT_CLR, .SLEEP, .BUS_ERR);
  swfd_host_model u_host (.CLK, .slow, .REG_RD, .REG_WR, .REG_BANK,
    .REG_ADDR, .REG_WDATA, .TX_REQ, .TX_BIT, .REG_RDATA, .REG_RVALID,
    .TX_DONE);
  task cmp(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task av(input w, input [3:0] a, input [31:0] wd);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 0;
    AVS_READ <= 0;
  endtask
  task sym(input b);
    @(posedge CLK);
    SYM_VALID <= 1;
    SYM_BIT <= b;
    @(posedge CLK);
    SYM_VALID <= 0;
    @(posedge CLK);
  endtask
  task brk;
    @(posedge CLK);
    SYM_BREAK <= 1;
    @(posedge CLK);
    SYM_BREAK <= 0;
  endtask
  task frame(input cs, input [1:0] op, bk, input [7:0] a, input [2:0] n);
    reg [15:0] f;
    f = {n, a, bk, op, cs};
    for (int i = 0; i < 16; i++) sym(f[i]);
  endtask
  task rd(input [1:0] op, bk, input [7:0] a, input [2:0] cc);
    int n, k, s;
    reg [7:0] c, d;
    n = (cc == 7) ? 16 : cc + (op == 2) * 0;
    s = stats;
    u_host.bits.delete();
    frame(0, op, bk, a, cc);
    k = 0;
    while (u_host.bits.size() < 8 * (n + (op == 2)) && k < 4000) begin
      @(posedge CLK);
      k++;
    end
    repeat (20) @(posedge CLK);
    cmp(u_host.bits.size(), 8 * (n + (op == 2)));
    cmp(stats - s, (bk == 1 && a == 1 && cc == 1));
    c = 0;
    for (int i = 0; i < n + (op == 2); i++) begin
      d = (i < n) ? ({8'(a + i)} << 2 | bk) ^ 8'ha5 : c;
      q = 0;
      for (int j = 0; j < 8; j++) begin
        if (i < n) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[j]) ? 8'h8c : 8'h00);
        q[j] = u_host.bits[8 * i + j];
      end
      cmp(q[7:0], d);
    end
  endtask
  task wr(input [1:0] bk, input [7:0] a, input [2:0] n);
    int k;
    reg [7:0] v[4];
    u_host.wq.delete();
    frame(0, 0, bk, a, n);
    for (int i = 0; i < n; i++) begin
      v[i] = $urandom;
      for (int j = 0; j < 8; j++) sym(v[i][j]);
    end
    k = 0;
    while (u_host.wq.size() < n && k < 100) begin
      @(posedge CLK);
      k++;
    end
    for (int i = 0; i < n; i++)
      cmp(u_host.wq[i], {bk, 8'(a + i), v[i]});
  endtask
  initial begin
    q = $urandom(96);
    repeat (16) @(posedge CLK);
    RESET <= 0;
    av(0, 4'h0, 0);
    cmp(q, 32'h4);
    av(0, 4'hc, 0);
    cmp(q, 0);
    $display("test registers done");
    wr(1, 8'h00, 1);
    wr(0, 8'h03, 2);
    wr(2, 8'h01, 4);
    $display("test write done");
    for (int o = 1; o < 3; o++) begin
      slow <= $urandom;
      rd(o, 0, 8'h05, 4);
      rd(o, 0, 8'h01, 7);
      rd(o, 1, 8'h01, 1);
      rd(o, 3, 8'h00, 2);
    end
    wr(1, 8'h00, 2);
    $display("test read done");
    e0 = errs;
    for (int i = 0; i < 6; i++) begin
      brk;
      frame(0, i == 5 ? 0 : 1, i == 5 ? 2 : 1, i == 5, cl[i]);
    end
    brk;
    SYM_GLITCH <= 1;
    @(posedge CLK);
    SYM_GLITCH <= 0;
    brk;
    cmp(errs - e0, 7);
    av(0, 4'h4, 0);
    cmp(q[0], 1);
    av(1, 4'h4, 1);
    av(0, 4'h4, 0);
    cmp(q[0], 0);
    $display("test error done");
    av(1, 4'h0, 32'ha);
    av(0, 4'h0, 0);
    cmp(q, 32'ha);
    e0 = errs;
    brk;
    frame(0, 1, 0, 8'h01, 7);
    brk;
    cmp(errs - e0, 1);
    rd(1, 1, 8'h00, 1);
    av(1, 4'h0, 32'h4);
    $display("test lock and speed done");
    brk;
    sym(0);
    sym(1);
    sym(1);
    cmp(SLEEP, 1);
    brk;
    @(posedge CLK);
    cmp(SLEEP, 0);
    e0 = u_host.rd_n;
    frame(1, 1, 1, 8'h00, 1);
    repeat (60) @(posedge CLK);
    cmp(u_host.rd_n, e0);
    brk;
    $display("test sleep and select done");
    finish_test;
  end
  initial begin
    #(25 * 60000);
    miscompares++;
    finish_test;
  end
endmodule // swfd_frame_decoder_test
